// ===== hdl/epp_pkg.sv
// Purpose: Shared constants and types of the EPP cycle engine
// Assumes: 125 MHz system clock, AHB-Lite word registers
// Notes: Byte address of a register is four times its index
package epp_pkg;
	// Clock and watchdog timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int WD_TIMEOUT_NS = 10000;
	// Longest time, so round down
	localparam int WD_CYCLES = WD_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int WD_W = 11;

	// Register indices
	localparam logic [3:0] IDX_DATA = 4'h0;
	localparam logic [3:0] IDX_STATUS = 4'h1;
	localparam logic [3:0] IDX_CONTROL = 4'h2;
	localparam logic [3:0] IDX_EPP_ADDR = 4'h3;
	localparam logic [3:0] IDX_EPP_DATA0 = 4'h4;
	localparam logic [3:0] IDX_EPP_DATA3 = 4'h7;
	localparam logic [3:0] IDX_MODE = 4'h8;

	// Control register fields
	localparam int CTL_STROBE = 0;
	localparam int CTL_AUTOFD = 1;
	localparam int CTL_INIT = 2;
	localparam int CTL_SLCTIN = 3;
	localparam int CTL_IRQE = 4;
	localparam int CTL_DIR = 5;
	localparam logic [5:0] CONTROL_RST = 6'h00;

	// Mode register fields
	localparam int MODE_EPP = 0;
	localparam int MODE_V19 = 1;
	localparam logic [1:0] MODE_RST = 2'h0;

	// Status register fields
	localparam int STS_CYCLE_TIMEOUT_FLAG = 0;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// Parallel control pins, all active low
	typedef struct packed {
		logic n_write;
		logic n_datastb;
		logic n_addrstb;
		logic n_init;
	} pins_s;

	localparam pins_s PINS_RST = 4'hF;

	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_START = 7'h02,
		S_WLOW = 7'h04,
		S_DRIVE = 7'h08,
		S_STRB = 7'h10,
		S_TERM = 7'h20,
		S_HOLD = 7'h40
	} state_e;
endpackage

// ===== hdl/epp_parallel_cycle_engine.sv
// Purpose: EPP 1.7/1.9 cycle engine behind an AHB-Lite slave
// Assumes: Port inputs are synchronous to clk_sys_i
// Notes: Bus wait states stand in for the ISA ready line
`timescale 1ns/100ps
module epp_parallel_cycle_engine
	import epp_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [7:0] port_data_bus_i,
	output logic [7:0] port_data_bus_o,
	output logic port_data_bus_oe_o,
	output logic port_direction_out_o,
	output pins_s pins_o,
	input wire logic n_wait_i,
	input wire logic busy_i,
	input wire logic n_ack_i,
	input wire logic pe_i,
	input wire logic slct_i,
	input wire logic n_err_i,
	input wire logic peripheral_interrupt_in_i,
	output logic peripheral_interrupt_o
);
	state_e state_r;
	state_e state_nxt;
	logic [5:0] ctrl_r;
	logic [5:0] ctrl_nxt;
	logic [1:0] mode_r;
	logic [1:0] mode_nxt;
	logic [7:0] spp_data_r;
	logic [7:0] spp_data_nxt;
	logic [7:0] out_byte_r;
	logic [7:0] out_byte_nxt;
	logic cycle_timeout_flag_r;
	logic cycle_timeout_flag_nxt;
	logic [WD_W-1:0] wd_r;
	logic [WD_W-1:0] wd_nxt;
	logic is_read_r;
	logic is_addr_r;
	logic wr_pend_r;
	logic [3:0] wr_idx_r;
	logic [31:0] hrdata_nxt;
	logic hreadyout_nxt;
	logic cyc_nxt;
	logic strobe_nxt;
	logic dir_nxt;
	pins_s pins_nxt;
	logic [7:0] pd_nxt;

	// Address phase decode
	wire [3:0] acc_idx = haddr_i[5:2];
	wire accept = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ);
	wire epp_en = mode_r[MODE_EPP];
	wire v19 = mode_r[MODE_V19];
	wire epp_hit = epp_en & ((acc_idx == IDX_EPP_ADDR) | ((acc_idx >= IDX_EPP_DATA0) & (acc_idx <= IDX_EPP_DATA3)));
	wire acc_epp = accept & epp_hit;
	wire acc_reg = accept & ~epp_hit;
	wire control_direction_bit = ctrl_r[CTL_DIR];

	// Watchdog runs while ready is held low
	wire wd_busy = (state_r == S_START) | (state_r == S_WLOW) | (state_r == S_DRIVE) | (state_r == S_STRB);
	wire timeout = wd_busy & (wd_r >= WD_CYCLES[WD_W-1:0]);
	// nWAIT high is the peripheral's acknowledge
	wire capture = (state_r == S_STRB) & n_wait_i & ~timeout;

	// Software writes land in the zero-wait data phase
	wire wr_data = wr_pend_r & (wr_idx_r == IDX_DATA);
	wire wr_ctrl = wr_pend_r & (wr_idx_r == IDX_CONTROL);
	wire wr_mode = wr_pend_r & (wr_idx_r == IDX_MODE);
	wire wr_sts = wr_pend_r & (wr_idx_r == IDX_STATUS);
	wire tmo_clr = wr_sts & hwdata_i[STS_CYCLE_TIMEOUT_FLAG];

	// Register read mux, unmapped reads return zero
	wire [7:0] status_byte = {~busy_i, n_ack_i, pe_i, slct_i, n_err_i, 2'b00, cycle_timeout_flag_r};
	wire [31:0] rd_mux = (acc_idx == IDX_DATA) ? {24'h000000, port_data_bus_i} :
		(acc_idx == IDX_STATUS) ? {24'h000000, status_byte} :
		(acc_idx == IDX_CONTROL) ? {26'h0000000, ctrl_r} :
		(acc_idx == IDX_MODE) ? {30'h00000000, mode_r} : 32'h00000000;

	// Cycle sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE, S_TERM, S_HOLD: begin
				state_nxt = acc_epp ? S_START : S_IDLE;
			end
			S_START: begin
				state_nxt = (v19 & n_wait_i) ? S_WLOW : S_DRIVE;
			end
			S_WLOW: begin
				if (timeout) begin
					state_nxt = S_TERM;
				end else if (!n_wait_i) begin
					state_nxt = S_DRIVE;
				end
			end
			S_DRIVE: begin
				state_nxt = timeout ? S_TERM : S_STRB;
			end
			S_STRB: begin
				if (timeout) begin
					state_nxt = S_TERM;
				end else if (n_wait_i) begin
					state_nxt = v19 ? S_TERM : S_HOLD;
				end
			end
			default: begin
				state_nxt = S_IDLE;
			end
		endcase
	end

	// Ready is low in every state that still waits on the port
	assign hreadyout_nxt = ~((state_nxt == S_START) | (state_nxt == S_WLOW) |
		(state_nxt == S_DRIVE) | (state_nxt == S_STRB));
	assign cyc_nxt = (state_nxt == S_DRIVE) | (state_nxt == S_STRB) | (state_nxt == S_TERM) | (state_nxt == S_HOLD);
	// 1.7 keeps the strobe up for the cycle in which the host ends
	assign strobe_nxt = (state_nxt == S_STRB) | (state_nxt == S_HOLD);
	// Control strobe forces write; a set direction bit turns writes into reads
	assign dir_nxt = cyc_nxt ? ((is_read_r | control_direction_bit) & ~ctrl_r[CTL_STROBE]) : control_direction_bit;
	assign out_byte_nxt = (state_r == S_START) ? hwdata_i[7:0] : out_byte_r;
	assign pd_nxt = cyc_nxt ? out_byte_nxt : spp_data_r;

	// Pins follow control register outside a cycle
	assign pins_nxt.n_write = cyc_nxt ? dir_nxt : ~ctrl_r[CTL_STROBE];
	assign pins_nxt.n_datastb = cyc_nxt ? ~(strobe_nxt & ~is_addr_r) : ~ctrl_r[CTL_AUTOFD];
	assign pins_nxt.n_addrstb = cyc_nxt ? ~(strobe_nxt & is_addr_r) : ~ctrl_r[CTL_SLCTIN];
	assign pins_nxt.n_init = ctrl_r[CTL_INIT];

	// Set wins over the write-one clear
	assign cycle_timeout_flag_nxt = timeout | (cycle_timeout_flag_r & ~tmo_clr);
	assign wd_nxt = (wd_busy & (state_nxt != S_TERM) & (state_nxt != S_HOLD)) ? WD_W'(wd_r + 1'b1) : '0;
	assign ctrl_nxt = wr_ctrl ? hwdata_i[5:0] : ctrl_r;
	assign mode_nxt = wr_mode ? hwdata_i[1:0] : mode_r;
	assign spp_data_nxt = wr_data ? hwdata_i[7:0] : spp_data_r;
	assign hrdata_nxt = capture ? {24'h000000, port_data_bus_i} : (acc_reg ? rd_mux : hrdata_o);

	// Sequencer and counters
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state_r <= S_IDLE;
			wd_r <= '0;
			cycle_timeout_flag_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			wd_r <= wd_nxt;
			cycle_timeout_flag_r <= cycle_timeout_flag_nxt;
		end
	end

	// Software registers and latched request
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ctrl_r <= CONTROL_RST;
			mode_r <= MODE_RST;
			spp_data_r <= 8'h00;
			out_byte_r <= 8'h00;
		end else begin
			ctrl_r <= ctrl_nxt;
			mode_r <= mode_nxt;
			spp_data_r <= spp_data_nxt;
			out_byte_r <= out_byte_nxt;
		end
	end

	// Access kind captured in the address phase
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			is_read_r <= 1'b0;
			is_addr_r <= 1'b0;
			wr_pend_r <= 1'b0;
			wr_idx_r <= 4'h0;
		end else begin
			if (acc_epp) begin
				is_read_r <= ~hwrite_i;
				is_addr_r <= (acc_idx == IDX_EPP_ADDR);
			end
			wr_pend_r <= acc_reg & hwrite_i;
			wr_idx_r <= acc_idx;
		end
	end

	// All outputs registered
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			hrdata_o <= 32'h00000000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
			pins_o <= PINS_RST;
			port_data_bus_o <= 8'h00;
			port_data_bus_oe_o <= 1'b1;
			port_direction_out_o <= 1'b0;
			peripheral_interrupt_o <= 1'b0;
		end else begin
			hrdata_o <= hrdata_nxt;
			hreadyout_o <= hreadyout_nxt;
			hresp_o <= 1'b0;
			pins_o <= pins_nxt;
			port_data_bus_o <= pd_nxt;
			port_data_bus_oe_o <= ~dir_nxt;
			port_direction_out_o <= dir_nxt;
			// Passed through like standard mode, gated by the enable bit
			peripheral_interrupt_o <= peripheral_interrupt_in_i & ctrl_r[CTL_IRQE];
		end
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence seq_strobe_up;
		!pins_o.n_datastb || !pins_o.n_addrstb;
	endsequence
	sequence seq_strobe_down;
		pins_o.n_datastb && pins_o.n_addrstb;
	endsequence

	ready_low_a: assert property (acc_epp |=> !hreadyout_o)
		else $error("ready not pulled low at EPP start");
	wait_low_a: assert property ((state_r == S_WLOW) && n_wait_i |=> seq_strobe_down)
		else $error("strobe moved while nWAIT high");
	// Checked on the drive-to-strobe step; a drive that ends in TERM is not a fault
	write_drive_a: assert property ((state_r == S_DRIVE) && !timeout && !is_read_r && !control_direction_bit && !ctrl_r[CTL_STROBE]
		|=> (port_data_bus_oe_o && !pins_o.n_write && !port_direction_out_o) and seq_strobe_up)
		else $error("write cycle pins wrong");
	term_release_a: assert property (capture && v19 |=> hreadyout_o and seq_strobe_down)
		else $error("1.9 termination wrong");
	read_capture_a: assert property (capture |=> hrdata_o[7:0] == $past(port_data_bus_i))
		else $error("read byte not captured");
	read_float_a: assert property ((state_r == S_STRB) && is_read_r && !ctrl_r[CTL_STROBE]
		|=> !port_data_bus_oe_o && port_direction_out_o && pins_o.n_write)
		else $error("read cycle pins wrong");
	wd_abort_a: assert property (timeout |=> (cycle_timeout_flag_r && hreadyout_o) and seq_strobe_down)
		else $error("watchdog did not abort");
	tmo_clear_a: assert property (cycle_timeout_flag_r && tmo_clr && !timeout |=> !cycle_timeout_flag_r)
		else $error("timeout flag not cleared");
	v17_stretch_a: assert property (!v19 && (state_r == S_STRB) && !n_wait_i && !timeout
		|=> !hreadyout_o)
		else $error("1.7 ready released while nWAIT low");
	// HOLD keeps the strobe low for one cycle with ready already high
	v17_hold_a: assert property (!v19 && capture |=> (hreadyout_o and seq_strobe_up) ##1 seq_strobe_down)
		else $error("1.7 strobe not held to host end");
	idle_dir_a: assert property ((state_r == S_IDLE) && $past(state_r == S_IDLE)
		|=> port_direction_out_o == $past(control_direction_bit))
		else $error("idle direction not following control");
	irq_pass_a: assert property (##1 peripheral_interrupt_o == $past(peripheral_interrupt_in_i & ctrl_r[CTL_IRQE]))
		else $error("interrupt not passed through");
	wd_bound_a: assert property (wd_r <= WD_CYCLES[WD_W-1:0])
		else $error("watchdog exceeded limit");
endmodule

// ===== bench/epp_periph_model.sv
// Purpose: Behavioural EPP peripheral on the far side of the port
// Assumes: Strobes and nWAIT sampled on clk_sys_i
// Notes: delay_i 8'hFF never raises nWAIT, to provoke the watchdog
`timescale 1ns/100ps
module epp_periph_model
	import epp_pkg::*;
(
	input wire logic clk_sys_i,
	input wire pins_s pins_i,
	input wire logic [7:0] bus_i,
	input wire logic [7:0] delay_i,
	input wire logic idle_hi_i,
	input wire logic [7:0] rd_byte_i,
	output logic n_wait_o,
	output logic [7:0] bus_o,
	output logic [7:0] got_o
);
	logic [7:0] cnt_r = 8'h00;
	wire strobe_on = !pins_i.n_datastb || !pins_i.n_addrstb;
	initial begin
		n_wait_o = 1'b0;
		bus_o = 8'h5A;
		got_o = 8'h00;
	end
	// Read byte goes out with the strobe, so it is valid before nWAIT rises
	always @(posedge clk_sys_i) begin
		bus_o <= (strobe_on && pins_i.n_write) ? rd_byte_i : ~bus_o;
		if (!strobe_on) begin
			cnt_r <= 8'h00;
			n_wait_o <= idle_hi_i;
		end else if (cnt_r == delay_i && delay_i != 8'hFF) begin
			n_wait_o <= 1'b1;
			got_o <= bus_i;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
endmodule

// ===== bench/test_epp_parallel_cycle_engine.sv
// Purpose: Self-checking bench of the EPP cycle engine
// Assumes: One AHB master, peripheral model on the port
// Notes: Watchdog runs at its full 1250 cycles
`timescale 1ns/100ps
module test_epp_parallel_cycle_engine;
	import epp_pkg::*;
	typedef struct packed {logic v19; logic [3:0] idx; logic wr; logic [7:0] val; logic [7:0] dly;} row_s;
	logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, n_wait, irq_in = 1'b0, idle_hi = 1'b0, busy = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_v;
	logic [1:0] htrans = 2'h0;
	logic hreadyout, hresp, oe, dir, irq_out, strb_q = 1'b0;
	logic [7:0] pbus_o, per_bus, got, dly = 8'h02, rd_byte = 8'hC3;
	logic [2:0] snap = 3'h0;
	pins_s pins;
	int miscompares = 0, checks_done = 0, waits = 0;
	row_s rows [6] = '{'{1, 4'h4, 1, 8'hA5, 8'h01}, '{1, 4'h3, 1, 8'h3C, 8'h06},
		'{1, 4'h5, 0, 8'h96, 8'h14}, '{1, 4'h3, 0, 8'h01, 8'h02},
		'{0, 4'h7, 1, 8'hFE, 8'h04}, '{0, 4'h6, 0, 8'h7F, 8'h01}};
	// Shared port bus: whoever has it enabled sets the level
	wire [7:0] bus_w = oe ? pbus_o : per_bus;
	wire strb_now = !pins.n_datastb || !pins.n_addrstb;
	epp_parallel_cycle_engine i_epp_parallel_cycle_engine (.clk_sys_i(clk), .rst_n_i(rst_n), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
		.port_data_bus_i(bus_w), .port_data_bus_o(pbus_o), .port_data_bus_oe_o(oe),
		.port_direction_out_o(dir), .pins_o(pins), .n_wait_i(n_wait), .busy_i(busy), .n_ack_i(1'b1),
		.pe_i(1'b0), .slct_i(1'b1), .n_err_i(1'b1), .peripheral_interrupt_in_i(irq_in),
		.peripheral_interrupt_o(irq_out));
	epp_periph_model i_epp_periph_model (.clk_sys_i(clk), .pins_i(pins), .bus_i(bus_w), .delay_i(dly),
		.idle_hi_i(idle_hi), .rd_byte_i(rd_byte), .n_wait_o(n_wait), .bus_o(per_bus), .got_o(got));
	initial begin
		forever #4 clk = ~clk;
	end
	// Snapshot of direction, write line and strobe choice as a strobe starts
	always @(posedge clk) begin
		strb_q <= strb_now;
		if (strb_now && !strb_q) snap <= {dir, pins.n_write, !pins.n_addrstb};
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// One single transfer; called just after a rising edge
	task automatic xfer(input logic [3:0] idx, input logic wr, input logic [31:0] wd);
		int n;
		n = 0;
		hsel <= 1'b1; haddr <= {26'h0, idx, 2'h0}; htrans <= HTRANS_NONSEQ; hwrite <= wr;
		@(posedge clk);
		while (hreadyout !== 1'b1 && n < 3000) begin n++; @(posedge clk); end
		htrans <= 2'h0; hwdata <= wd; waits = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1 && waits < 3000) begin waits++; @(posedge clk); end
		rd_v = hrdata;
		if (n >= 3000 || waits >= 3000) miscompares++;
	endtask
	// Hang guard, well beyond the longest expected run
	initial begin
		repeat (25000) @(posedge clk);
		miscompares++;
		print_verdict();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk); @(posedge clk);
		check({hreadyout, hresp, dir, oe, pins}, {4'h9, 4'hE});
		xfer(IDX_STATUS, 0, 0); check(rd_v, 32'hD8);
		$display("reset test done");
		foreach (rows[i]) begin
			xfer(IDX_MODE, 1, {30'h0, rows[i].v19, 1'b1});
			xfer(IDX_CONTROL, 1, (!rows[i].v19 && !rows[i].wr) ? 32'h20 : 32'h00);
			dly <= rows[i].dly; rd_byte <= rows[i].val;
			xfer(rows[i].idx, rows[i].wr, {24'hFFFFFF, rows[i].val});
			check({31'h0, waits >= 3}, 1);
			check(snap, {!rows[i].wr, !rows[i].wr, rows[i].idx == 4'h3});
			if (rows[i].wr) check(got, rows[i].val);
			else check(rd_v, {24'h0, rows[i].val});
			$display("row %0d done", i);
		end
		// Wait line high at the start holds everything still
		xfer(IDX_MODE, 1, 32'h3); xfer(IDX_CONTROL, 1, 0); dly <= 8'h02; idle_hi <= 1'b1;
		@(posedge clk); @(posedge clk);
		fork
			xfer(IDX_EPP_DATA0, 1, 32'h69);
			begin
				repeat (12) @(posedge clk);
				check({dir, pins}, 5'h0E);
				idle_hi <= 1'b0;
			end
		join
		check(got, 8'h69);
		$display("wait-high test done");
		// Watchdog in both variants, then flag clearing
		for (int m = 3; m > 0; m -= 2) begin
			xfer(IDX_MODE, 1, m); dly <= 8'hFF;
			xfer(IDX_EPP_DATA3, 1, 32'h11);
			check({31'h0, waits > 1200 && waits < 1260}, 1);
			// TERM still drives the write line; idle pins show one edge later
			@(posedge clk);
			check({dir, pins}, 5'h0E);
			xfer(IDX_STATUS, 1, 0); xfer(IDX_STATUS, 0, 0); check(rd_v[0], 1);
			xfer(IDX_STATUS, 1, 1); xfer(IDX_STATUS, 0, 0); check(rd_v[0], 0);
		end
		dly <= 8'h01;
		$display("timeout test done");
		// Control pins and direction outside cycles; EPP refused when disabled
		xfer(IDX_MODE, 1, 0); xfer(IDX_CONTROL, 1, 32'h2F);
		// New control reaches the pins one edge after its data phase
		@(posedge clk); @(posedge clk);
		check({dir, oe, pins}, 6'h21);
		xfer(IDX_EPP_DATA0, 1, 32'h55); check(waits, 0);
		xfer(IDX_EPP_DATA0, 0, 0); check(rd_v, 0);
		xfer(4'hF, 0, 0); check(rd_v, 0);
		busy <= 1'b1; xfer(IDX_STATUS, 0, 0); check(rd_v, 32'h58);
		// Enable bit clear: a raised interrupt must stay hidden
		irq_in <= 1'b1; repeat (3) @(posedge clk);
		check(irq_out, 0);
		xfer(IDX_CONTROL, 1, 32'h10); irq_in <= 1'b1; repeat (3) @(posedge clk);
		check(irq_out, 1);
		irq_in <= 1'b0; repeat (3) @(posedge clk);
		check(irq_out, 0);
		$display("misc test done");
		print_verdict();
	end
endmodule
